//--- src/hts_pkg.sv
// Constants and types shared by the humidity and temperature sensor controller
package hts_pkg;
  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_NS     = 10;
  localparam int US_NS      = 1000;
  localparam int TICK_CYC   = US_NS / CLK_NS;
  localparam int SPIKE_NS   = 50;
  localparam int FILT_CYC   = SPIKE_NS / CLK_NS + 1;
  localparam int STARTUP_US = 15000;
  localparam int T_T14_US   = 6350;
  localparam int T_T11_US   = 3650;
  localparam int T_H14_US   = 6500;
  localparam int T_H11_US   = 3850;
  localparam int T_H8_US    = 2500;
  // ****************************************
  // Bus address and pointers
  // ****************************************
  localparam logic [4:0] ADDR_HI    = 5'h10;
  localparam logic [7:0] PTR_TEMP   = 8'h00;
  localparam logic [7:0] PTR_HUM    = 8'h01;
  localparam logic [7:0] PTR_CFG    = 8'h02;
  localparam logic [7:0] PTR_SER_LO = 8'hFB;
  // ****************************************
  // Configuration register fields
  // ****************************************
  localparam int          CFG_HEATER_ENABLE   = 13;
  localparam int          CFG_MODE   = 12;
  localparam int          CFG_SUPPLY_LOW_FLAG   = 11;
  localparam int          CFG_TRES   = 10;
  localparam int          CFG_HRES   = 8;
  localparam logic [15:0] CFG_RESET  = 16'h1000;
  localparam logic [1:0]  HRES_11    = 2'h1;
  localparam logic [1:0]  HRES_8     = 2'h2;
  typedef enum logic [2:0] {I_IDLE, I_RX, I_ACK, I_TX, I_TXACK} hts_i2c_t;
  typedef enum logic [1:0] {K_ADDR, K_PTR, K_DATA} hts_kind_t;
  typedef enum logic [1:0] {M_SLEEP, M_TEMP, M_HUM} hts_meas_t;
endpackage : hts_pkg

//--- src/hts_ctrl.sv
// Two-wire slave, mode machine and configuration of the humidity sensor
`timescale 1ns/1ps
module hts_ctrl #(
  parameter int          STARTUP_US = hts_pkg::STARTUP_US,
  parameter int          T_T14_US   = hts_pkg::T_T14_US,
  parameter int          T_T11_US   = hts_pkg::T_T11_US,
  parameter int          T_H14_US   = hts_pkg::T_H14_US,
  parameter int          T_H11_US   = hts_pkg::T_H11_US,
  parameter int          T_H8_US    = hts_pkg::T_H8_US,
  parameter logic [15:0] SER_FB     = 16'hA5A5, // Arbitrary value
  parameter logic [15:0] SER_FC     = 16'h5A5A, // Arbitrary value
  parameter logic [15:0] SER_FD     = 16'hC300, // Arbitrary value
  parameter logic [15:0] ID_FE      = 16'h0101, // Arbitrary value
  parameter logic [15:0] ID_FF      = 16'h0202  // Arbitrary value
) (
  input  wire logic        CLOCK_IN,              // 100 MHz clock
  input  wire logic        SRST_IN,               // Sync reset, high
  input  wire logic        SCL_IN,                // Bus clock pin
  input  wire logic        SDA_IN,                // Bus data pin level
  output logic             SDA_OUT,               // Bus data drive value
  output logic             SDA_OE_N_OUT,          // Low while pulling data low
  input  wire logic        BUS_ID_STRAP_LO_IN,    // Address strap, bit 0
  input  wire logic        BUS_ID_STRAP_HI_IN,    // Address strap, bit 1
  input  wire logic        SUPPLY_LOW_IN,         // Supply monitor below 2.8 V
  input  wire logic [15:0] TEMP_SAMPLE_IN,        // Temperature converter word
  input  wire logic [15:0] HUM_SAMPLE_IN,         // Humidity converter word
  output logic             CONVERSION_DONE_N_OUT, // Result ready, low
  output logic             HEATER_ON_OUT,         // Heater power
  output logic             MEAS_ACTIVE_OUT        // Measurement mode
);
  // ****************************************
  // Pin synchronisers and spike filters
  // ****************************************
  logic [1:0]      s1, s2, st1, st2, filt, filt_q;
  logic            sup1, sup2;
  logic [1:0][2:0] fcnt;
  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
    begin
      s1 <= 2'h3; s2 <= 2'h3; st1 <= 2'h0; st2 <= 2'h0;
      sup1 <= 1'b0; sup2 <= 1'b0; filt_q <= 2'h3;
    end
    else
    begin
      s1 <= {SDA_IN, SCL_IN}; s2 <= s1;
      st1 <= {BUS_ID_STRAP_HI_IN, BUS_ID_STRAP_LO_IN}; st2 <= st1;
      sup1 <= SUPPLY_LOW_IN; sup2 <= sup1;
      filt_q <= filt;
    end
  end
  // A new level is taken only after it held longer than a spike can last
  for (genvar gi = 0; gi < 2; gi++)
  begin : g_filt
    always_ff @(posedge CLOCK_IN)
    begin
      if (SRST_IN)
      begin
        fcnt[gi] <= 3'h0; filt[gi] <= 1'b1;
      end
      else if (s2[gi] == filt[gi])
        fcnt[gi] <= 3'h0;
      else if (fcnt[gi] == 3'(hts_pkg::FILT_CYC - 1))
      begin
        filt[gi] <= s2[gi]; fcnt[gi] <= 3'h0;
      end
      else
        fcnt[gi] <= fcnt[gi] + 3'h1;
    end
  end
  wire scl = filt[0];
  wire sda = filt[1];
  wire scl_rise = scl & ~filt_q[0];
  wire scl_fall = ~scl & filt_q[0];
  wire start = scl & filt_q[0] & filt_q[1] & ~sda;
  wire stop  = scl & filt_q[0] & ~filt_q[1] & sda;
  // ****************************************
  // Microsecond tick and start-up timer
  // ****************************************
  logic [6:0]  tick_cnt;
  logic [13:0] su_cnt;
  logic        su_done, tick;
  assign tick = (tick_cnt == 7'(hts_pkg::TICK_CYC - 1));
  wire su_fin = tick & ~su_done & (su_cnt == 14'(STARTUP_US - 1));
  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
    begin
      tick_cnt <= 7'h0; su_cnt <= 14'h0; su_done <= 1'b0;
    end
    else
    begin
      tick_cnt <= tick ? 7'h0 : tick_cnt + 7'h1;
      if (tick & ~su_done)
        su_cnt <= su_cnt + 14'h1;
      if (su_fin)
        su_done <= 1'b1;
    end
  end
  // ****************************************
  // Two-wire slave
  // ****************************************
  hts_pkg::hts_i2c_t  i_st, next_i_st;
  hts_pkg::hts_kind_t kind, next_kind;
  logic [3:0]  bcnt, next_bcnt;
  logic [7:0]  sh, next_sh, ptr, next_ptr, hi_b, next_hi_b;
  logic [1:0]  id_lat, next_id_lat, rd_idx, next_rd_idx, hres, next_hres;
  logic        rw, next_rw, dbyte, next_dbyte, drv, next_drv;
  logic        heater_enable, next_heater_enable, mode, next_mode, tres, next_tres;
  logic        trig, trig_hum, rd_res, ok;
  logic [15:0] temp_res, hum_res, word;
  logic [7:0]  tx_b;
  logic        t_ok, h_ok, supply_low;
  hts_pkg::hts_meas_t m_st, next_m_st;
  function automatic logic ptr_ser(input logic [7:0] p);
    ptr_ser = (p >= hts_pkg::PTR_SER_LO);
  endfunction : ptr_ser
  function automatic logic ptr_ok(input logic [7:0] p);
    ptr_ok = (p <= hts_pkg::PTR_CFG) || ptr_ser(p);
  endfunction : ptr_ok
  wire [15:0] cfg_word = {2'h0, heater_enable, mode, supply_low, tres, hres, 8'h00};
  wire        res_rdy = (ptr == hts_pkg::PTR_TEMP) ? t_ok : h_ok;
  wire        addr_hit = (sh[7:1] == {hts_pkg::ADDR_HI, id_lat});
  always_comb
  begin
    word = 16'h0000;
    if (ptr == hts_pkg::PTR_TEMP && mode && rd_idx[1])
      word = hum_res;
    else if (ptr == hts_pkg::PTR_TEMP)
      word = temp_res;
    else if (ptr == hts_pkg::PTR_HUM)
      word = hum_res;
    else if (ptr == hts_pkg::PTR_CFG)
      word = cfg_word;
    else if (ptr == 8'hFB)
      word = SER_FB;
    else if (ptr == 8'hFC)
      word = SER_FC;
    else if (ptr == 8'hFD)
      word = SER_FD;
    else if (ptr == 8'hFE)
      word = ID_FE;
    else if (ptr == 8'hFF)
      word = ID_FF;
    tx_b = rd_idx[0] ? word[7:0] : word[15:8];
  end
  always_comb
  begin
    next_i_st = i_st; next_kind = kind; next_bcnt = bcnt; next_sh = sh;
    next_ptr = ptr; next_hi_b = hi_b; next_id_lat = id_lat; next_rd_idx = rd_idx;
    next_rw = rw; next_dbyte = dbyte; next_drv = drv; next_heater_enable = heater_enable;
    next_mode = mode; next_tres = tres; next_hres = hres;
    trig = 1'b0; trig_hum = 1'b0; rd_res = 1'b0; ok = 1'b0;
    if (start)
    begin
      next_i_st = hts_pkg::I_RX; next_kind = hts_pkg::K_ADDR;
      next_bcnt = 4'h0; next_drv = 1'b0;
      next_id_lat = st2;
    end
    else if (stop)
    begin
      next_i_st = hts_pkg::I_IDLE; next_drv = 1'b0;
    end
    else
    begin
      case (i_st)
        hts_pkg::I_RX:
          if (scl_rise)
          begin
            next_sh = {sh[6:0], sda};
            next_bcnt = bcnt + 4'h1;
          end
          else if (scl_fall && bcnt == 4'h8)
          begin
            case (kind)
              hts_pkg::K_ADDR:
              begin
                next_rw = sh[0];
                // Result reads need a ready result; start-up serves serial and identity reads only
                ok = addr_hit && (!sh[0] || (su_done ? (ptr > hts_pkg::PTR_HUM || res_rdy)
                                                     : ptr_ser(ptr)));
                next_rd_idx = 2'h0;
              end
              hts_pkg::K_PTR:
              begin
                ok = ptr_ok(sh) && (su_done || ptr_ser(sh));
                if (ok)
                begin
                  next_ptr = sh;
                  trig = (sh <= hts_pkg::PTR_HUM);
                  trig_hum = (sh == hts_pkg::PTR_HUM);
                end
                next_dbyte = 1'b0;
              end
              default:
              begin
                // Result and identity words are read-only
                ok = (ptr == hts_pkg::PTR_CFG);
                next_dbyte = ~dbyte;
                if (ok && !dbyte)
                  next_hi_b = sh;
                else if (ok)
                begin
                  next_heater_enable = hi_b[hts_pkg::CFG_HEATER_ENABLE - 8];
                  next_mode = hi_b[hts_pkg::CFG_MODE - 8];
                  next_tres = hi_b[hts_pkg::CFG_TRES - 8];
                  next_hres = hi_b[hts_pkg::CFG_HRES - 7 : hts_pkg::CFG_HRES - 8];
                end
              end
            endcase
            next_drv = ok;
            next_i_st = ok ? hts_pkg::I_ACK : hts_pkg::I_IDLE;
          end
        hts_pkg::I_ACK:
          if (scl_fall)
          begin
            next_drv = 1'b0; next_bcnt = 4'h0;
            next_kind = (kind == hts_pkg::K_ADDR) ? hts_pkg::K_PTR : hts_pkg::K_DATA;
            next_i_st = hts_pkg::I_RX;
            if (kind == hts_pkg::K_ADDR && rw)
              next_i_st = hts_pkg::I_TX;
            if (kind == hts_pkg::K_ADDR && rw)
            begin
              next_sh = tx_b; next_drv = ~tx_b[7]; next_bcnt = 4'h1;
              next_rd_idx = rd_idx + 2'h1;
              rd_res = (ptr <= hts_pkg::PTR_HUM);
            end
          end
        hts_pkg::I_TX:
          if (scl_fall && bcnt == 4'h8)
          begin
            next_drv = 1'b0; next_i_st = hts_pkg::I_TXACK;
          end
          else if (scl_fall)
          begin
            next_sh = {sh[6:0], 1'b0}; next_drv = ~sh[6]; next_bcnt = bcnt + 4'h1;
          end
        hts_pkg::I_TXACK:
          if (scl_rise && sda)
            next_i_st = hts_pkg::I_IDLE;
          else if (scl_fall)
          begin
            next_i_st = hts_pkg::I_TX; next_sh = tx_b; next_drv = ~tx_b[7];
            next_bcnt = 4'h1; next_rd_idx = rd_idx + 2'h1;
          end
        default: ;
      endcase
    end
  end
  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
    begin
      i_st <= hts_pkg::I_IDLE; kind <= hts_pkg::K_ADDR; bcnt <= 4'h0; sh <= 8'h00;
      ptr <= hts_pkg::PTR_TEMP; hi_b <= 8'h00; id_lat <= 2'h0; rd_idx <= 2'h0;
      rw <= 1'b0; dbyte <= 1'b0; drv <= 1'b0;
      heater_enable <= hts_pkg::CFG_RESET[hts_pkg::CFG_HEATER_ENABLE];
      mode <= hts_pkg::CFG_RESET[hts_pkg::CFG_MODE];
      tres <= hts_pkg::CFG_RESET[hts_pkg::CFG_TRES];
      hres <= hts_pkg::CFG_RESET[hts_pkg::CFG_HRES +: 2];
    end
    else
    begin
      i_st <= next_i_st; kind <= next_kind; bcnt <= next_bcnt; sh <= next_sh;
      ptr <= next_ptr; hi_b <= next_hi_b; id_lat <= next_id_lat; rd_idx <= next_rd_idx;
      rw <= next_rw; dbyte <= next_dbyte; drv <= next_drv; heater_enable <= next_heater_enable;
      mode <= next_mode; tres <= next_tres; hres <= next_hres;
    end
  end
  assign SDA_OUT = 1'b0;
  assign SDA_OE_N_OUT = ~drv;
  // ****************************************
  // Measurement mode machine
  // ****************************************
  logic [12:0] m_cnt, next_m_cnt, dur;
  logic [15:0] next_temp_res, next_hum_res;
  logic        next_t_ok, next_h_ok, done_n, next_done_n, next_supply_low;
  logic        hum_after, next_hum_after, heater, next_heater, m_fin;
  always_comb
  begin
    if (m_st == hts_pkg::M_TEMP)
      dur = tres ? 13'(T_T11_US) : 13'(T_T14_US);
    else if (hres == hts_pkg::HRES_11)
      dur = 13'(T_H11_US);
    else if (hres == hts_pkg::HRES_8)
      dur = 13'(T_H8_US);
    else
      dur = 13'(T_H14_US);
  end
  always_comb
  begin
    next_m_st = m_st; next_m_cnt = m_cnt; next_temp_res = temp_res;
    next_hum_res = hum_res; next_t_ok = t_ok; next_h_ok = h_ok;
    next_done_n = done_n; next_supply_low = supply_low; next_hum_after = hum_after;
    m_fin = 1'b0;
    if (rd_res)
      next_done_n = 1'b1;
    if (su_fin)
      next_supply_low = sup2;
    // A new trigger aborts whatever is running
    if (trig)
    begin
      next_supply_low = sup2;
      next_done_n = 1'b1;
      next_m_cnt = 13'h0;
      next_hum_after = mode && !trig_hum;
      next_m_st = trig_hum ? hts_pkg::M_HUM : hts_pkg::M_TEMP;
      if (trig_hum || mode)
        next_h_ok = 1'b0;
      if (!trig_hum)
        next_t_ok = 1'b0;
    end
    else if (m_st != hts_pkg::M_SLEEP && tick)
    begin
      next_m_cnt = m_cnt + 13'h1;
      if (m_cnt == dur - 13'h1)
      begin
        next_m_cnt = 13'h0;
        if (m_st == hts_pkg::M_TEMP)
        begin
          next_temp_res = TEMP_SAMPLE_IN;
          next_t_ok = !hum_after;
        end
        else
        begin
          next_hum_res = HUM_SAMPLE_IN; next_h_ok = 1'b1; next_t_ok = t_ok | hum_after;
        end
        m_fin = (m_st == hts_pkg::M_HUM) || !hum_after;
        next_m_st = m_fin ? hts_pkg::M_SLEEP : hts_pkg::M_HUM;
        if (m_fin)
          next_done_n = 1'b0;
      end
    end
    // Next heater bit, so clearing it mid-measurement cannot leave power on a cycle
    next_heater = next_heater_enable && (next_m_st != hts_pkg::M_SLEEP);
  end
  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
    begin
      m_st <= hts_pkg::M_SLEEP; m_cnt <= 13'h0;
      temp_res <= 16'h0000; hum_res <= 16'h0000; t_ok <= 1'b0; h_ok <= 1'b0;
      done_n <= 1'b1; supply_low <= 1'b0; hum_after <= 1'b0; heater <= 1'b0;
    end
    else
    begin
      m_st <= next_m_st; m_cnt <= next_m_cnt; temp_res <= next_temp_res;
      hum_res <= next_hum_res; t_ok <= next_t_ok; h_ok <= next_h_ok;
      done_n <= next_done_n; supply_low <= next_supply_low;
      hum_after <= next_hum_after; heater <= next_heater;
    end
  end
  assign CONVERSION_DONE_N_OUT = done_n;
  assign HEATER_ON_OUT = heater;
  assign MEAS_ACTIVE_OUT = (m_st != hts_pkg::M_SLEEP);
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (SRST_IN);
  property p_rst_sleep;
    @(posedge CLOCK_IN) disable iff (1'b0) SRST_IN |=> m_st == hts_pkg::M_SLEEP && done_n;
  endproperty
  a_rst_sleep: assert property (p_rst_sleep) else $error("not asleep after reset");
  property p_trig;
    trig |=> m_st != hts_pkg::M_SLEEP && done_n;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger did not start");
  property p_fin;
    m_fin |=> !done_n && m_st == hts_pkg::M_SLEEP;
  endproperty
  a_fin: assert property (p_fin) else $error("finish did not flag done");
  property p_supply_low_flag;
    trig |=> supply_low == $past(sup2);
  endproperty
  a_supply_low_flag: assert property (p_supply_low_flag) else $error("supply flag not refreshed");
  property p_heater_enable;
    HEATER_ON_OUT |-> MEAS_ACTIVE_OUT && heater_enable;
  endproperty
  a_heater_enable: assert property (p_heater_enable) else $error("heater on in sleep");
  property p_addr;
    i_st == hts_pkg::I_RX && kind == hts_pkg::K_ADDR && scl_fall && bcnt == 4'h8
      && !addr_hit && !start && !stop |=> !drv ##1 !drv;
  endproperty
  a_addr: assert property (p_addr) else $error("foreign address acknowledged");
  property p_spike;
    $changed(filt[0]) |-> $past(s2[0], 1) == filt[0] && $past(s2[0], 6) == filt[0];
  endproperty
  a_spike: assert property (p_spike) else $error("spike passed filter");
  property p_notready;
    i_st == hts_pkg::I_RX && kind == hts_pkg::K_ADDR && scl_fall && bcnt == 4'h8 && sh[0]
      && ptr <= hts_pkg::PTR_HUM && !res_rdy && !start && !stop |=> i_st == hts_pkg::I_IDLE;
  endproperty
  a_notready: assert property (p_notready) else $error("unready result acked");
  property p_startup;
    !su_done && i_st == hts_pkg::I_ACK |-> kind != hts_pkg::K_DATA;
  endproperty
  a_startup: assert property (p_startup) else $error("data taken in start-up");
  c_meas: cover property (trig ##1 MEAS_ACTIVE_OUT [*3] ##[1:1000] m_fin);
  c_read: cover property (rd_res ##1 i_st == hts_pkg::I_TX);
  c_cfg: cover property (i_st == hts_pkg::I_ACK && kind == hts_pkg::K_DATA && dbyte == 1'b0);
endmodule : hts_ctrl

//--- tb/hts_i2c_master.sv
// Behavioural two-wire bus master for the sensor controller bench
`timescale 1ns/1ps
module hts_i2c_master #(
  parameter int HALF = 16 // Clocks per SCL half; wider than link rate to cover filter lag
) (
  input  wire logic clk_in,  // Bench clock
  input  wire logic sda_in,  // Resolved data line
  output logic      scl_out, // Bus clock, stands high between frames
  output logic      sda_out  // Zero pulls data low
);
  logic glitch = 1'b0;
  initial
  begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask : tick
  // Data moves mid low phase, apart from the optional glitch spike, so no false start or stop is seen
  task automatic start_cond();
    tick(HALF / 2);
    sda_out = 1'b1;
    tick(HALF / 2);
    scl_out = 1'b1;
    tick(HALF);
    sda_out = 1'b0;
    tick(HALF);
    scl_out = 1'b0;
  endtask : start_cond
  task automatic stop_cond();
    tick(HALF / 2);
    sda_out = 1'b0;
    tick(HALF / 2);
    scl_out = 1'b1;
    tick(HALF);
    sda_out = 1'b1;
    tick(HALF);
  endtask : stop_cond
  task automatic bit_io(input logic b, output logic r);
    tick(HALF / 2);
    sda_out = b;
    tick(HALF / 2);
    scl_out = 1'b1;
    tick(HALF / 2);
    if (glitch)
      sda_out = ~b; // 40 ns spike while clock is high
    tick(4);
    sda_out = b;
    tick(HALF / 2 - 5);
    r = sda_in;
    tick(1);
    scl_out = 1'b0;
  endtask : bit_io
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : send_byte
  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask : recv_byte
endmodule : hts_i2c_master

//--- tb/tb_top.sv
// Self-checking bench for the sensor controller
`timescale 1ns/1ps
module tb_top;
  // Durations differ by at least 2 us so a wrong resolution falls outside the window
  localparam int ST   = 40;
  localparam int TT14 = 10;
  localparam int TT11 = 8;
  localparam int TH14 = 10;
  localparam int TH11 = 8;
  localparam int TH8  = 6;
  logic clk, srst, s_lo, s_hi, supply, sflag, sda_o, oe_n, done_n, heater, meas, scl, sda_m;
  logic [15:0] temp, hum, c;
  logic [6:0]  dev;
  int          cyc = 0, n_mismatch = 0, tests_run = 0;
  wire         sda_line = sda_m & (oe_n | sda_o);
  hts_i2c_master u_hts_i2c_master (.clk_in(clk), .sda_in(sda_line), .scl_out(scl), .sda_out(sda_m));
  hts_ctrl #(.STARTUP_US(ST), .T_T14_US(TT14), .T_T11_US(TT11), .T_H14_US(TH14),
    .T_H11_US(TH11), .T_H8_US(TH8), .SER_FB(16'h1234)) u_hts_ctrl (
    .CLOCK_IN(clk), .SRST_IN(srst), .SCL_IN(scl), .SDA_IN(sda_line), .SDA_OUT(sda_o),
    .SDA_OE_N_OUT(oe_n), .BUS_ID_STRAP_LO_IN(s_lo), .BUS_ID_STRAP_HI_IN(s_hi),
    .SUPPLY_LOW_IN(supply), .TEMP_SAMPLE_IN(temp), .HUM_SAMPLE_IN(hum),
    .CONVERSION_DONE_N_OUT(done_n), .HEATER_ON_OUT(heater), .MEAS_ACTIVE_OUT(meas));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic finish_test();
    $display("Checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check
  // Stops sending at the first refused byte
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic dat, output int na);
    logic [7:0] bs [4];
    logic       k;
    bs = '{{a, 1'b0}, p, c[15:8], c[7:0]};
    na = 0;
    u_hts_i2c_master.start_cond();
    for (int j = 0; j < (dat ? 4 : 2) && j == na; j++)
    begin
      u_hts_i2c_master.send_byte(bs[j], k);
      na += int'(k);
    end
    u_hts_i2c_master.stop_cond();
  endtask : wr
  task automatic rd(input int n, output logic ak, output logic [31:0] d);
    logic [7:0] b;
    d = '0;
    u_hts_i2c_master.start_cond();
    u_hts_i2c_master.send_byte({dev, 1'b1}, ak);
    for (int k = 0; k < n && ak; k++)
    begin
      u_hts_i2c_master.recv_byte(k == n - 1, b);
      d = {d[23:0], b};
    end
    u_hts_i2c_master.stop_cond();
  endtask : rd
  function automatic int conv_us(logic [15:0] w, logic [7:0] p);
    int t = w[10] ? TT11 : TT14;
    int h = (w[9:8] == 2'h1) ? TH11 : (w[9:8] == 2'h2) ? TH8 : TH14;
    return (p == 8'h01) ? h : (w[12] ? t + h : t);
  endfunction : conv_us
  // ****************************************
  // Clock, timeout and main sequence
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 80000)
    begin
      n_mismatch++;
      finish_test();
    end
  end
  initial
  begin
    logic        ak;
    logic [31:0] d;
    logic [7:0]  p;
    int          na, t0, el;
    void'($urandom(45610));
    srst = 1'b1;
    {s_hi, s_lo} = 2'($urandom); // Straps settle before any bus activity
    supply = 1'($urandom);
    temp = 16'($urandom);
    hum = 16'($urandom);
    c = 16'h0000;
    repeat (10) @(negedge clk);
    srst = 1'b0;
    sflag = supply;
    dev = {5'h10, s_hi, s_lo};
    check("done_n idle", 1, done_n);
    check("meas idle", 0, meas);
    check("heater idle", 0, heater);
    wr(dev, 8'h02, 1'b0, na);
    check("startup cfg ptr", 1, na);
    wr(dev, 8'hFB, 1'b0, na);
    rd(2, ak, d);
    check("startup serial", 16'h1234, d);
    while (cyc < ST * 100 + 100) @(negedge clk);
    for (int k = 1; k < 4; k++)
    begin
      wr(dev ^ 7'(k), 8'h02, 1'b0, na);
      check("foreign addr", 0, na);
    end
    for (int i = 0; i < 6; i++)
    begin
      c = 16'($urandom);
      c[13] = i[1];
      c[12] = (i < 3);
      c[10] = i[0];
      c[9:8] = 2'(i % 3);
      p = (i > 2 && i[0]) ? 8'h01 : 8'h00;
      u_hts_i2c_master.glitch = (i == 2);
      wr(dev, 8'h02, 1'b1, na);
      u_hts_i2c_master.glitch = 1'b0;
      check("cfg acks", 4, na);
      rd(2, ak, d);
      check("cfg", (c & 16'h3700) | {4'h0, sflag, 11'h000}, d);
      supply = 1'($urandom);
      temp = 16'($urandom);
      hum = 16'($urandom);
      wr(dev, p, 1'b0, na);
      t0 = cyc;
      sflag = supply;
      check("trigger acks", 2, na);
      check("meas on", 1, meas);
      check("heater on", c[13], heater);
      check("done_n on trigger", 1, done_n);
      rd(2, ak, d);
      check("early read ack", 0, ak);
      for (int w = 0; w < 3000 && done_n !== 1'b0; w++) @(negedge clk);
      // Trigger lands about 71 cycles before the write returns; tick phase adds 0 to 99
      el = cyc - t0 - conv_us(c, p) * 100;
      check("conversion time", 1, el > -190 && el < -50);
      check("meas off", 0, meas);
      check("heater off", 0, heater);
      rd((c[12] && p == 8'h00) ? 4 : 2, ak, d);
      check("result ack", 1, ak);
      check("result", (p == 8'h01) ? hum : (c[12] ? {temp, hum} : temp), d);
      check("done_n after read", 1, done_n);
    end
    // Retrigger while done is still low: it must be released and a new run begun
    wr(dev, 8'h00, 1'b0, na);
    for (int w = 0; w < 3000 && done_n !== 1'b0; w++) @(negedge clk);
    check("done_n before retrigger", 0, done_n);
    wr(dev, 8'h01, 1'b0, na);
    check("done_n on retrigger", 1, done_n);
    check("meas on retrigger", 1, meas);
    {s_hi, s_lo} = {s_hi, s_lo} ^ 2'h3;
    dev = {5'h10, s_hi, s_lo};
    wr(dev, 8'h02, 1'b0, na);
    check("new strap addr", 2, na);
    wr(dev ^ 7'h03, 8'h02, 1'b0, na);
    check("old strap addr", 0, na);
    finish_test();
  end
endmodule : tb_top
